/* File: tcc_pkg.sv */
// shared constants, register map and carrier types of the two-channel compare control
package tcc_pkg;
    // register byte offsets
    localparam logic [7:0] TCC_INTEN_OFF  = 8'h0c;  // request enable bits
    localparam logic [7:0] TCC_FLAG_OFF   = 8'h10;  // sticky event flags, write 0 clears
    localparam logic [7:0] TCC_SWEVG_OFF  = 8'h14;  // software_event_trigger
    localparam logic [7:0] TCC_CHCFG_OFF  = 8'h18;  // channel_mode_config
    localparam logic [7:0] TCC_CV_A_OFF   = 8'h34;  // channel a compare/capture value
    localparam logic [7:0] TCC_CV_STEP    = 8'h04;  // spacing of the value registers
    // event and flag bit positions
    localparam int TCC_UPD_BIT  = 0;                // update event / flag
    localparam int TCC_CHA_BIT  = 1;                // channel a event / flag
    localparam int TCC_CHB_BIT  = 2;                // channel b event / flag
    localparam int TCC_TRG_BIT  = 6;                // trigger event / flag
    localparam int TCC_OFA_BIT  = 9;                // channel a over-capture flag
    localparam int TCC_CHAN_STRIDE = 8;             // config bits per channel
    localparam int TCC_MS_LSB   = 0;                // mode selector inside a channel byte
    // writable masks and reset values
    localparam logic [31:0] TCC_CHCFG_MASK = 32'h0000_7f7f;
    localparam logic [31:0] TCC_FLAG_MASK  = 32'h0000_0647;
    localparam logic [31:0] TCC_INTEN_MASK = 32'h0000_0047;
    localparam logic [6:0]  TCC_SWEVG_MASK = 7'h47;
    localparam logic [31:0] TCC_RESET_VAL  = 32'h0000_0000;
    // mode selector codes
    localparam logic [1:0] TCC_MS_OUTPUT = 2'h0;    // channel drives the reference
    localparam logic [1:0] TCC_MS_OWN    = 2'h1;    // own filtered input
    localparam logic [1:0] TCC_MS_OTHER  = 2'h2;    // other channel's filtered input
    localparam logic [1:0] TCC_MS_ITRIG  = 2'h3;    // internal trigger
    // compare control codes
    typedef enum logic [2:0] {
        TCC_CMP_TIMING = 3'h0, TCC_CMP_SET   = 3'h1, TCC_CMP_CLEAR = 3'h2,
        TCC_CMP_TOGGLE = 3'h3, TCC_CMP_LOW   = 3'h4, TCC_CMP_HIGH  = 3'h5,
        TCC_CMP_PWM0   = 3'h6, TCC_CMP_PWM1  = 3'h7
    } tcc_cmp_t;
    // one channel byte of channel_mode_config
    typedef struct packed {
        logic          rsv;        // reserved, reads zero
        tcc_cmp_t      cmp_ctl;    // compare control
        logic          shadow_en;  // compare value shadowing
        logic          fast_en;    // trigger acts as match in pwm
        logic [1:0]    mode_sel;   // output or input source
    } tcc_chan_cfg_t;
    // per-channel side inputs from the enable/polarity register
    typedef struct packed {
        logic enable;              // channel active
        logic polarity;            // main output polarity
        logic comp_polarity;       // complementary output polarity
    } tcc_chan_ctl_t;
endpackage

/* File: tcc_tb.sv */
// self-checking bench for the two-channel compare control block
`timescale 1ns/1ps
module testbench;
    import tcc_pkg::*;
    logic              clk        = 1'b0;   // 20 mhz timer clock
    logic              rst        = 1'b1;   // async reset, high
    logic [7:0]        reg_addr   = 8'h00;
    logic [31:0]       reg_wdata  = 32'h0;
    logic              reg_wr     = 1'b0;
    logic              reg_rd     = 1'b0;
    logic [31:0]       reg_rdata;
    logic [15:0]       cnt_value  = 16'h0;  // counter core stand-in
    logic              cnt_down   = 1'b0;
    logic              cnt_update = 1'b0;
    logic              trig_edge  = 1'b0;
    tcc_chan_ctl_t     chan_ctl [2];
    logic              cnt_clear;
    logic              update_pulse;
    logic [3:0]        event_req;
    logic [1:0]        chan_output;
    logic [1:0]        chan_comp_output;
    int                error_cnt  = 0;
    int                n_checks   = 0;
    int                clr_n      = 0;      // cnt_clear pulses seen
    int                upd_n      = 0;      // update_pulse pulses seen
    logic [31:0]       rv;
    // compare walk: {config, counter, down, pulse, expected reference}
    localparam logic [26:0] TBL [16] = '{
        {8'h50, 16'h000, 3'b001}, {8'h40, 16'h000, 3'b000}, {8'h10, 16'h000, 3'b000},
        {8'h10, 16'h100, 3'b001}, {8'h20, 16'h100, 3'b000}, {8'h30, 16'h000, 3'b000},
        {8'h30, 16'h100, 3'b011}, {8'h00, 16'h000, 3'b001}, {8'h60, 16'h080, 3'b001},
        {8'h60, 16'h180, 3'b000}, {8'h60, 16'h180, 3'b100}, {8'h60, 16'h080, 3'b101},
        {8'h00, 16'h080, 3'b101}, {8'h70, 16'h080, 3'b000}, {8'h70, 16'h180, 3'b001},
        {8'h70, 16'h080, 3'b100}};

    always #25 clk = ~clk;

    tcc_top #(.CNT_W(16)) uut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cnt_value(cnt_value), .cnt_down(cnt_down), .cnt_update(cnt_update),
        .trig_edge(trig_edge), .chan_ctl(chan_ctl), .cnt_clear(cnt_clear),
        .update_pulse(update_pulse), .event_req(event_req),
        .chan_output(chan_output), .chan_comp_output(chan_comp_output));

    // count one-cycle pulses so their number, not their phase, is checked
    always @(posedge clk) begin
        if (cnt_clear === 1'b1) clr_n++;
        if (update_pulse === 1'b1) upd_n++;
    end

    // compare and report
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one-cycle word write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // one-cycle read, data taken in the following cycle only
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        chk(reg_rdata, exp);
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // output pins of one channel against a reference level, polarity bits zero
    task automatic pins(input int ch, input logic ref_lvl);
        @(negedge clk);
        chk({30'h0, chan_comp_output[ch], chan_output[ch]}, {30'h0, ~ref_lvl, ref_lvl});
        @(posedge clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // watchdog, run needs well under 40 us
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        chan_ctl[0] = '0;
        chan_ctl[1] = '0;
        idle(5);
        rst <= 1'b0;
        rdchk(TCC_SWEVG_OFF, 32'h0);
        rdchk(TCC_CHCFG_OFF, 32'h0);
        // every config field writable while both channels are off
        wr(TCC_CHCFG_OFF, 32'hffff_ffff);
        rdchk(TCC_CHCFG_OFF, 32'h0000_7f7f);
        // enabled channels keep their mode selectors
        chan_ctl[0].enable <= 1'b1;
        chan_ctl[1].enable <= 1'b1;
        wr(TCC_CHCFG_OFF, 32'h0);
        rdchk(TCC_CHCFG_OFF, 32'h0000_0303);
        chan_ctl[0].enable <= 1'b0;
        chan_ctl[1].enable <= 1'b0;
        wr(TCC_CHCFG_OFF, 32'h0);
        rdchk(TCC_CHCFG_OFF, 32'h0);
        // both selectors on internal trigger; source picked elsewhere
        wr(TCC_CHCFG_OFF, 32'h0303);
        rdchk(TCC_CHCFG_OFF, 32'h0303);
        wr(TCC_CHCFG_OFF, 32'h0);
        // trigger event: flag, request, self-clear, no counter clear
        wr(TCC_INTEN_OFF, 32'h47);
        wr(TCC_SWEVG_OFF, 32'h40);
        rdchk(TCC_SWEVG_OFF, 32'h0);
        rdchk(TCC_FLAG_OFF, 32'h40);
        chk({28'h0, event_req}, 32'h8);
        chk(clr_n, 0);
        wr(TCC_FLAG_OFF, 32'h0);
        // update event clears counter once and pulses once
        wr(TCC_SWEVG_OFF, 32'h01);
        idle(3);
        chk(clr_n, 1);
        chk(upd_n, 1);
        rdchk(TCC_FLAG_OFF, 32'h01);
        rdchk(TCC_SWEVG_OFF, 32'h0);
        wr(TCC_FLAG_OFF, 32'h0);
        // both channel events in one write, same cycle, in output mode, no capture
        wr(TCC_SWEVG_OFF, 32'h06);
        idle(3);
        rdchk(TCC_FLAG_OFF, 32'h06);
        chk({28'h0, event_req}, 32'h6);
        wr(TCC_FLAG_OFF, 32'h0);
        // two captures in input mode: second one overruns
        wr(TCC_CHCFG_OFF, 32'h0001);
        cnt_value <= 16'h1234;
        wr(TCC_SWEVG_OFF, 32'h02);
        idle(2);
        cnt_value <= 16'h2345;
        wr(TCC_SWEVG_OFF, 32'h02);
        idle(2);
        rdchk(TCC_FLAG_OFF, 32'h202);
        rdchk(TCC_CV_A_OFF, 32'h2345);
        wr(TCC_FLAG_OFF, 32'h0);
        wr(TCC_CHCFG_OFF, 32'h0);
        // output compare walk on channel a, compare value 0x100, no shadow
        cnt_value <= 16'h0;
        chan_ctl[0].enable <= 1'b1;
        wr(TCC_CV_A_OFF, 32'h100);
        for (int i = 0; i < 16; i++) begin
            if (TBL[i][1]) begin
                // toggle needs a single matching cycle
                wr(TCC_CHCFG_OFF, {24'h0, TBL[i][26:19]});
                @(posedge clk);
                cnt_value <= TBL[i][18:3];
                @(posedge clk);
                cnt_value <= 16'h0;
            end else begin
                @(posedge clk);
                cnt_value <= TBL[i][18:3];
                cnt_down  <= TBL[i][2];
                idle(2);
                wr(TCC_CHCFG_OFF, {24'h0, TBL[i][26:19]});
            end
            idle(4);
            pins(0, TBL[i][0]);
        end
        // shadowed value waits for the update event, checked in pwm0; shadow off again for the fast test
        cnt_down <= 1'b0;
        wr(TCC_CHCFG_OFF, 32'h00);
        wr(TCC_CHCFG_OFF, 32'h68);
        wr(TCC_CV_A_OFF, 32'h50);
        idle(4);
        pins(0, 1'b1);
        @(posedge clk);
        cnt_update <= 1'b1;
        @(posedge clk);
        cnt_update <= 1'b0;
        idle(4);
        pins(0, 1'b0);
        // fast enable: trigger edge acts as a match in pwm0
        wr(TCC_CHCFG_OFF, 32'h64);
        cnt_value <= 16'h10;
        idle(4);
        pins(0, 1'b1);
        @(posedge clk);
        trig_edge <= 1'b1;
        @(posedge clk);
        trig_edge <= 1'b0;
        idle(4);
        pins(0, 1'b0);
        // channel b forced high, then both polarity bits flipped
        chan_ctl[0].enable <= 1'b0;
        chan_ctl[1].enable <= 1'b1;
        wr(TCC_CHCFG_OFF, 32'h5000);
        idle(4);
        pins(1, 1'b1);
        chan_ctl[1].polarity      <= 1'b1;
        chan_ctl[1].comp_polarity <= 1'b1;
        idle(4);
        chk({30'h0, chan_comp_output[1], chan_output[1]}, 32'h2);
        // unmapped place reads zero and swallows writes
        wr(8'hfc, 32'hffff_ffff);
        rdchk(8'hfc, 32'h0);
        rdchk(TCC_CHCFG_OFF, 32'h5000);
        give_verdict();
    end
endmodule

/* File: tcc_top.sv */
// two-channel software event generation and output compare control
// Operation
// - trigger generation bit self-clears after acting
// - trigger generation sets trigger flag and request
// - channel generation self-clears, sets flag, requests
// - input-mode channel event captures counter, overcapture
// - update generation clears counters, makes update event
// - channel b selector: output or three inputs
// - mode selector writable only while channel disabled
// - channel a selector: output or three inputs
// - compare match: keep, set, clear, toggle
// - compare codes force reference low or high
// - pwm0: high below compare counting up
// - pwm1: low below compare counting up
// - pwm reference changes only on result change, on leaving the timing code or on a fast trigger hit
// - reference high is active, polarity shapes outputs
// - shadowed compare value loads on update event
// - fast enable treats trigger edge as match
// - channel b fields mirror channel a fields
// - channel b enable gates its match flag and locks its selector
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module tcc_top #(
    parameter int CNT_W = 16                     // counter width
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output      logic [31:0]           reg_rdata,
    input  wire logic [CNT_W-1:0]      cnt_value,
    input  wire logic                  cnt_down,
    input  wire logic                  cnt_update,
    input  wire logic                  trig_edge,
    input  wire tcc_pkg::tcc_chan_ctl_t chan_ctl [2],
    output      logic                  cnt_clear,
    output      logic                  update_pulse,
    output      logic [3:0]            event_req,
    output      logic [1:0]            chan_output,
    output      logic [1:0]            chan_comp_output
);
    import tcc_pkg::*;

    // register state
    logic [31:0]      chcfg_q;                   // channel_mode_config
    logic [31:0]      flag_q;                    // sticky flags
    logic [31:0]      inten_q;                   // request enables
    logic [6:0]       swevg_q;                   // pending generation bits
    logic [31:0]      rdata_q;                   // read data stage
    logic             cnt_clear_q;               // counter clear pulse
    logic             update_q;                  // update event pulse
    logic [3:0]       req_q;                     // request lines
    logic [1:0]       out_q;                     // main outputs
    logic [1:0]       cout_q;                    // complementary outputs
    logic [CNT_W-1:0] cv_act_q [2];              // active compare/capture value
    logic [CNT_W-1:0] cv_sh_q  [2];              // shadow compare value
    logic [1:0]       ref_q;                     // reference signals
    logic [1:0]       lvl_prev_q;                // last pwm comparison
    tcc_cmp_t         ctl_prev_q [2];            // last compare code

    // decode, named wires
    wire sel_inten = (reg_addr == TCC_INTEN_OFF);
    wire sel_flag  = (reg_addr == TCC_FLAG_OFF);
    wire sel_swevg = (reg_addr == TCC_SWEVG_OFF);
    wire sel_chcfg = (reg_addr == TCC_CHCFG_OFF);
    wire wr_swevg  = reg_wr && sel_swevg;
    wire wr_chcfg  = reg_wr && sel_chcfg;
    wire wr_flag   = reg_wr && sel_flag;
    // update event: software request or counter core overflow
    wire upd_now   = swevg_q[TCC_UPD_BIT] || cnt_update;
    wire trg_now   = swevg_q[TCC_TRG_BIT];

    // per-channel terms produced inside the generate loop, then the config write terms
    logic [1:0]       chf_set;                   // capture/compare flag set
    logic [1:0]       of_set;                    // over-capture flag set
    logic [1:0]       cv_rd_clr;                 // capture read clears flag
    logic [1:0]       ref_d;                     // next reference
    logic [1:0]       lvl;                       // pwm comparison level
    logic [1:0]       sel_cv;                    // value register selected
    logic [31:0]      chcfg_d;                   // next config word
    logic [31:0]      cfg_keep;                  // bits a write may change

    // mode selectors are locked while their channel is enabled
    always_comb begin
        cfg_keep = TCC_CHCFG_MASK;
        for (int i = 0; i < 2; i++) begin
            if (chan_ctl[i].enable) begin
                cfg_keep[i*TCC_CHAN_STRIDE + TCC_MS_LSB +: 2] = 2'h0;
            end
        end
        chcfg_d = (chcfg_q & ~cfg_keep) | (reg_wdata & cfg_keep);
    end


    // the generation bits live for exactly one clock; a second write in
    // the very next cycle simply latches again, nothing is queued
    // software event register: latched on write, acts and clears next clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            swevg_q <= 7'h00;
        end else if (wr_swevg) begin
            swevg_q <= reg_wdata[6:0] & TCC_SWEVG_MASK;
        end else begin
            swevg_q <= 7'h00;
        end
    end

    // configuration and enable registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chcfg_q <= TCC_RESET_VAL;
            inten_q <= TCC_RESET_VAL;
        end else begin
            if (wr_chcfg) begin
                chcfg_q <= chcfg_d;
            end
            if (reg_wr && sel_inten) begin
                inten_q <= reg_wdata & TCC_INTEN_MASK;
            end
        end
    end

    // flag set terms; a hardware set beats a software clear
    logic [31:0] flag_set;                       // set vector
    logic [31:0] flag_clr;                       // clear vector
    always_comb begin
        flag_set = 32'h0;
        flag_set[TCC_UPD_BIT] = upd_now;
        flag_set[TCC_CHA_BIT] = chf_set[0];
        flag_set[TCC_CHB_BIT] = chf_set[1];
        flag_set[TCC_TRG_BIT] = trg_now;
        flag_set[TCC_OFA_BIT] = of_set[0];
        flag_set[TCC_OFA_BIT+1] = of_set[1];
        flag_clr = wr_flag ? ~reg_wdata : 32'h0;
        flag_clr[TCC_CHA_BIT] = flag_clr[TCC_CHA_BIT] | cv_rd_clr[0];
        flag_clr[TCC_CHB_BIT] = flag_clr[TCC_CHB_BIT] | cv_rd_clr[1];
    end


    // flags are sticky; masking keeps reserved bits at zero even if
    // a set term were ever routed to a reserved position
    // flag register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= TCC_RESET_VAL;
        end else begin
            flag_q <= ((flag_q & ~flag_clr) | flag_set) & TCC_FLAG_MASK;
        end
    end

    // read mux, answer one clock after the strobe
    logic [31:0] rd_mux;                         // selected read word
    always_comb begin
        rd_mux = 32'h0;                          // unmapped and write-only read zero
        if (sel_chcfg) begin
            rd_mux = chcfg_q;
        end else if (sel_flag) begin
            rd_mux = flag_q;
        end else if (sel_inten) begin
            rd_mux = inten_q;
        end else if (sel_cv[0]) begin
            rd_mux = 32'(cv_act_q[0]);
        end else if (sel_cv[1]) begin
            rd_mux = 32'(cv_act_q[1]);
        end
    end

    // outputs toward the counter core and request lines
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q     <= 32'h0;
            cnt_clear_q <= 1'b0;
            update_q    <= 1'b0;
            req_q       <= 4'h0;
        end else begin
            rdata_q     <= reg_rd ? rd_mux : 32'h0;
            cnt_clear_q <= swevg_q[TCC_UPD_BIT];
            update_q    <= upd_now;
            req_q       <= {flag_q[TCC_TRG_BIT] & inten_q[TCC_TRG_BIT],
                            flag_q[TCC_CHB_BIT:TCC_UPD_BIT] & inten_q[2:0]};
        end
    end


    // both channels share one body; channel b sits one config byte up
    // and one value register further on
    // reference runs even while disabled, so enabling shows a settled level
    // per-channel compare, capture and reference logic
    for (genvar i = 0; i < 2; i++) begin : g_chan
        wire tcc_chan_cfg_t cfg = tcc_chan_cfg_t'(chcfg_q[i*TCC_CHAN_STRIDE +: 8]);
        wire is_input  = (cfg.mode_sel != TCC_MS_OUTPUT);
        wire gen_evt   = swevg_q[TCC_CHA_BIT + i];
        wire eq        = (cnt_value == cv_act_q[i]);
        wire lt        = (cnt_value <  cv_act_q[i]);
        wire gt        = (cnt_value >  cv_act_q[i]);
        wire is_pwm    = (cfg.cmp_ctl == TCC_CMP_PWM0) || (cfg.cmp_ctl == TCC_CMP_PWM1);
        // pwm0 level; pwm1 is its inverse
        wire pwm0      = cnt_down ? !gt : lt;
        wire fast_hit  = cfg.fast_en && is_pwm && trig_edge;
        // a forced match behaves as counter equal to the compare value
        wire fast_lvl  = (cfg.cmp_ctl == TCC_CMP_PWM0) ? cnt_down : !cnt_down;
        wire lvl_chg   = (lvl[i] != lvl_prev_q[i]) || (ctl_prev_q[i] == TCC_CMP_TIMING);
        wire match_evt = !is_input && chan_ctl[i].enable && eq;
        wire cv_sel    = (reg_addr == TCC_CV_A_OFF + 8'(i * TCC_CV_STEP));
        assign sel_cv[i]    = cv_sel;
        assign lvl[i]       = (cfg.cmp_ctl == TCC_CMP_PWM1) ? !pwm0 : pwm0;
        assign chf_set[i]   = gen_evt || match_evt;
        assign of_set[i]    = gen_evt && is_input && flag_q[TCC_CHA_BIT + i];
        assign cv_rd_clr[i] = reg_rd && cv_sel && is_input;

        // reference level by compare code
        always_comb begin
            case (cfg.cmp_ctl)
                TCC_CMP_TIMING: ref_d[i] = ref_q[i];
                TCC_CMP_SET:    ref_d[i] = eq ? 1'b1 : ref_q[i];
                TCC_CMP_CLEAR:  ref_d[i] = eq ? 1'b0 : ref_q[i];
                TCC_CMP_TOGGLE: ref_d[i] = eq ? !ref_q[i] : ref_q[i];
                TCC_CMP_LOW:    ref_d[i] = 1'b0;
                TCC_CMP_HIGH:   ref_d[i] = 1'b1;
                TCC_CMP_PWM0,
                TCC_CMP_PWM1:   ref_d[i] = fast_hit ? fast_lvl :
                                           (lvl_chg ? lvl[i] : ref_q[i]);
                default:        ref_d[i] = ref_q[i];
            endcase
        end

        // reference, history and outputs; high reference is the active level
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                ref_q[i]      <= 1'b0;
                lvl_prev_q[i] <= 1'b0;
                ctl_prev_q[i] <= TCC_CMP_TIMING;
                out_q[i]      <= 1'b0;
                cout_q[i]     <= 1'b0;
            end else begin
                ref_q[i]      <= ref_d[i];
                lvl_prev_q[i] <= lvl[i];
                ctl_prev_q[i] <= cfg.cmp_ctl;
                out_q[i]      <= ref_q[i] ^ chan_ctl[i].polarity;
                cout_q[i]     <= !ref_q[i] ^ chan_ctl[i].comp_polarity;
            end
        end

        // compare value: shadow copy reaches the active one on update
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cv_act_q[i] <= '0;
                cv_sh_q[i]  <= '0;
            end else begin
                if (reg_wr && cv_sel) begin
                    cv_sh_q[i] <= reg_wdata[CNT_W-1:0];
                end
                if (gen_evt && is_input) begin
                    cv_act_q[i] <= cnt_value;
                end else if (reg_wr && cv_sel && !cfg.shadow_en) begin
                    cv_act_q[i] <= reg_wdata[CNT_W-1:0];
                end else if (upd_now && cfg.shadow_en) begin
                    cv_act_q[i] <= cv_sh_q[i];
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata        = rdata_q;
    assign cnt_clear        = cnt_clear_q;
    assign update_pulse     = update_q;
    assign event_req        = req_q;
    assign chan_output      = out_q;
    assign chan_comp_output = cout_q;


    // assertions look at channel a, save the channel flag set check and the rules about channel b;
    // the body is shared, so one channel stands for both
    // checks gathered at the end of the module, after the output assigns
    a_trig_self_clear: assert property (@(posedge clk) disable iff (rst)
        swevg_q[TCC_TRG_BIT] && !wr_swevg |=> !swevg_q[TCC_TRG_BIT])
        else $error("trigger generation bit did not clear");
    a_trig_sets_flag: assert property (@(posedge clk) disable iff (rst)
        wr_swevg && reg_wdata[TCC_TRG_BIT] |=> ##1 flag_q[TCC_TRG_BIT])
        else $error("trigger flag not set by software event");
    a_chan_flag_set: assert property (@(posedge clk) disable iff (rst)
        wr_swevg && reg_wdata[TCC_CHB_BIT] |=> ##1 flag_q[TCC_CHB_BIT])
        else $error("channel flag not set by software event");
    a_capture_value: assert property (@(posedge clk) disable iff (rst)
        swevg_q[TCC_CHA_BIT] && chcfg_q[1:0] != TCC_MS_OUTPUT
        |=> cv_act_q[0] == $past(cnt_value))
        else $error("capture did not store the counter");
    a_over_capture: assert property (@(posedge clk) disable iff (rst)
        swevg_q[TCC_CHA_BIT] && chcfg_q[1:0] != TCC_MS_OUTPUT && flag_q[TCC_CHA_BIT]
        |=> flag_q[TCC_OFA_BIT])
        else $error("over-capture flag missing");
    a_update_clear: assert property (@(posedge clk) disable iff (rst)
        wr_swevg && reg_wdata[TCC_UPD_BIT] |=> ##1 cnt_clear && update_pulse)
        else $error("update generation did not clear the counter");
    a_mode_locked: assert property (@(posedge clk) disable iff (rst)
        wr_chcfg && chan_ctl[1].enable |=> $stable(chcfg_q[9:8]))
        else $error("mode selector changed while channel enabled");
    a_force_levels: assert property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_LOW |=> !ref_q[0])
        else $error("forced low reference not low");
    a_shadow_hold: assert property (@(posedge clk) disable iff (rst)
        reg_wr && sel_cv[0] && chcfg_q[3] && !upd_now && chcfg_q[1:0] == TCC_MS_OUTPUT
        |=> $stable(cv_act_q[0]))
        else $error("shadowed compare value changed without update");
    a_out_polarity: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> chan_output[0] == ($past(ref_q[0]) ^ $past(chan_ctl[0].polarity)))
        else $error("main output does not follow reference and polarity");
    c_capture: cover property (@(posedge clk) disable iff (rst)
        swevg_q[TCC_CHA_BIT] && chcfg_q[1:0] != TCC_MS_OUTPUT);
    c_pwm_edge: cover property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_PWM0 && $rose(ref_q[0]));
    c_fast_trig: cover property (@(posedge clk) disable iff (rst)
        chcfg_q[2] && chcfg_q[6:5] == 2'h3 && trig_edge);
    c_shadow_load: cover property (@(posedge clk) disable iff (rst)
        upd_now && chcfg_q[3]);

    c_over_capture: cover property (@(posedge clk) disable iff (rst) of_set[0]);

    // further checks on flags, generation bits, selector lock, reference codes, outputs, requests and value paths
    a_chan_a_flag: assert property (@(posedge clk) disable iff (rst)
        wr_swevg && reg_wdata[TCC_CHA_BIT] |=> ##1 flag_q[TCC_CHA_BIT])
        else $error("channel a flag not set by software event");

    a_upd_self_clear: assert property (@(posedge clk) disable iff (rst)
        swevg_q[TCC_UPD_BIT] && !wr_swevg |=> !swevg_q[TCC_UPD_BIT])
        else $error("update generation bit did not clear");

    a_force_high: assert property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_HIGH |=> ref_q[0])
        else $error("forced high reference not high");

    a_set_match: assert property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_SET && cnt_value == cv_act_q[0] |=> ref_q[0])
        else $error("reference not set on match");

    a_clear_match: assert property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_CLEAR && cnt_value == cv_act_q[0] |=> !ref_q[0])
        else $error("reference not cleared on match");

    a_timing_hold: assert property (@(posedge clk) disable iff (rst)
        chcfg_q[6:4] == TCC_CMP_TIMING |=> $stable(ref_q[0]))
        else $error("reference moved in timing mode");

    a_mode_a_locked: assert property (@(posedge clk) disable iff (rst)
        wr_chcfg && chan_ctl[0].enable |=> $stable(chcfg_q[1:0]))
        else $error("channel a selector changed while enabled");

    a_comp_polarity: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> chan_comp_output[0] ==
                 (!$past(ref_q[0]) ^ $past(chan_ctl[0].comp_polarity)))
        else $error("complementary output does not follow reference");

    a_req_trig: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> event_req[3] == $past(flag_q[TCC_TRG_BIT] & inten_q[TCC_TRG_BIT]))
        else $error("trigger request does not follow flag and enable");

    a_cv_direct: assert property (@(posedge clk) disable iff (rst)
        reg_wr && sel_cv[0] && !chcfg_q[3] && chcfg_q[1:0] == TCC_MS_OUTPUT
        |=> cv_act_q[0] == $past(reg_wdata[CNT_W-1:0]))
        else $error("unshadowed compare value not written directly");

    a_b_idle_flag: assert property (@(posedge clk) disable iff (rst)
        !swevg_q[TCC_CHB_BIT] && !chan_ctl[1].enable && !flag_q[TCC_CHB_BIT]
        |=> !flag_q[TCC_CHB_BIT])
        else $error("disabled channel b raised its flag");
endmodule
